/* core/bridge_peak_hold_channel_config.sv */
// serial config frames for output channels 4 and 5 with bridge and peak-and-hold grouping
//
// Overview of operation
// - bits 31:28 hold the command; code 0100 selects the channel-4 frame.
// - channel-5 frame printed as 0100 clashes; decoded here as code 0101.
// - bit 27 at 0 writes fields and replies; at 1 only replies.
// - bit 0 is 1 when the other bits hold an even count of ones.
// - channel-4 bit 26 groups channels 1 to 4 into bridge one.
// - channel-4 bit 24 runs channels 1 to 4 as peak-and-hold one.
// - bit 25 picks no-fault or no-diagnostic-done report in peak-and-hold.
// - bits 23:22 pick off-state diag time; ignored in bridge one without extension.
// - bit 21 picks fixed or compensated overcurrent threshold for readback.
// - bits 20:15 carry the six-bit overcurrent threshold code.
// - bits 14:13 select none or one of three thermal compensation ranges.
// - bit 12 switches supply-voltage compensation of overcurrent off or on.
// - bits 11:9 pick blank time; delays evaluation only in drain-source mode.
// - bit 8 picks restart policy; bridge channels always need a readout.
// - bit 7 picks drain-source monitoring or shunt sensing.
// - bit 6 picks 100 uA or 1 mA open-load test current.
// - bits 5:4 pick gate current: external, 20 mA, 5 mA, 1 mA.
// - bit 3 N/P transistor, bit 2 low/high side, bit 1 enable.
// - channel-5 bits 26:25 give bridge-two dead time 1, 2, 4, 8 us.
// - channel-5 bit 24 at 0 shares channel-5 diag timer with channels 6-8 while bridge two is enabled.
// - bridge two without extension uses the short diag table, else standard.
// - bridge-two extension only acts while bridge two is enabled.
`timescale 1ns/100ps
module bridge_peak_hold_channel_config (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              ce,
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              mosi,
    input  wire logic              bridge_two_group_enable,
    input  wire logic              bridge_one_timer_extension,
    output logic                   sdo,
    output logic                   sdo_en,
    output logic                   frame_done,
    output logic                   parity_error,
    output logic                   frame_error,
    output logic                   bridge_one_group_enable,
    output logic                   peak_hold_one_group_enable,
    output logic                   peak_hold_one_open_load_mask,
    output logic                   ph1_no_fault_report,
    output logic                   ph1_no_diag_report,
    output logic [1:0]             bridge_two_crossover_delay,
    output logic [9:0]             crossover_delay_cycles,
    output logic                   bridge_two_timer_extension,
    output logic                   shared_diag_timer,
    output logic                   ch4_diag_timer_active,
    output logic [1:0][15:0]       diag_time_t100ns,
    output logic [1:0]             overcurrent_readback_select,
    output logic [1:0][5:0]        overcurrent_threshold_code,
    output logic [1:0][1:0]        overcurrent_thermal_comp,
    output logic [1:0]             overcurrent_supply_comp,
    output logic [1:0][2:0]        overcurrent_blank_time,
    output logic [1:0][15:0]       blank_time_t100ns,
    output logic [1:0]             blank_delays_eval,
    output logic [1:0]             restart_policy,
    output logic [1:0]             restart_after_readout,
    output logic [1:0]             current_sense_method,
    output logic [1:0]             open_load_current_high,
    output logic [1:0][1:0]        gate_current_select,
    output logic [1:0]             pmos_select,
    output logic [1:0]             side_select,
    output logic [1:0]             output_enable
);

    ////////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers

    logic                          rst_meta_r;
    logic                          rst_sync_r;
    logic                          sclk_meta_r;
    logic                          sclk_s_r;
    logic                          sclk_d_r;
    logic                          cs_meta_r;
    logic                          cs_s_r;
    logic                          mosi_meta_r;
    logic                          mosi_s_r;
    logic                          sclk_rise;
    logic                          sclk_fall;

    // reset is taken asynchronously but is released on the clock
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else if (ce) begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // two stages per pin; the third sclk stage only serves edge detection
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            sclk_meta_r <= 1'b0;
            sclk_s_r    <= 1'b0;
            sclk_d_r    <= 1'b0;
            cs_meta_r   <= 1'b1;
            cs_s_r      <= 1'b1;
            mosi_meta_r <= 1'b0;
            mosi_s_r    <= 1'b0;
        end else if (ce) begin
            sclk_meta_r <= sclk;
            sclk_s_r    <= sclk_meta_r;
            sclk_d_r    <= sclk_s_r;
            cs_meta_r   <= cs_n;
            cs_s_r      <= cs_meta_r;
            mosi_meta_r <= mosi;
            mosi_s_r    <= mosi_meta_r;
        end
    end

    // sclk must stay well below a quarter of ref_clk for these edges to be seen
    assign sclk_rise = sclk_s_r & ~sclk_d_r;
    assign sclk_fall = ~sclk_s_r & sclk_d_r;

    ////////////////////////////////////////////////////////////////////////////////
    // frame state, receive and transmit shifters

    cfg_pkg::link_state_type       state_r;
    logic [31:0]                   rx_shift_r;
    logic [31:0]                   tx_shift_r;
    logic [31:0]                   reply_r;
    logic [5:0]                    bit_cnt_r;
    logic                          frame_ok;
    logic [26:1]                   reply_body;
    logic [1:0][26:1]              cfg_r;

    frame_if                       frm ();

    frame_decoder u_decoder (
        .f (frm)
    );

    assign frm.word = rx_shift_r;
    // length, command and parity all have to agree before anything is taken
    assign frame_ok = (bit_cnt_r == cfg_pkg::FRAME_LEN) && frm.parity_ok
                      && (frm.sel_ch4 || frm.sel_ch5);

    // sequencing: idle, shifting while selected, one cycle of evaluation
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            state_r <= cfg_pkg::LINK_IDLE;
        end else if (ce) begin
            case (state_r)
                cfg_pkg::LINK_IDLE: begin
                    if (!cs_s_r) begin
                        state_r <= cfg_pkg::LINK_SHIFT;
                    end
                end
                cfg_pkg::LINK_SHIFT: begin
                    if (cs_s_r) begin
                        state_r <= cfg_pkg::LINK_EVAL;
                    end
                end
                cfg_pkg::LINK_EVAL: begin
                    state_r <= cfg_pkg::LINK_IDLE;
                end
                default: begin
                    state_r <= cfg_pkg::LINK_IDLE;
                end
            endcase
        end
    end

    // bits enter msb first on rising sclk; the count saturates to flag long frames
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            rx_shift_r <= 32'h00000000;
            bit_cnt_r  <= 6'h00;
        end else if (ce) begin
            if (state_r == cfg_pkg::LINK_IDLE) begin
                bit_cnt_r <= 6'h00;
            end else if (state_r == cfg_pkg::LINK_SHIFT && !cs_s_r && sclk_rise) begin
                rx_shift_r <= {rx_shift_r[30:0], mosi_s_r};
                if (bit_cnt_r != cfg_pkg::CNT_MAX) begin
                    bit_cnt_r <= bit_cnt_r + 6'h01;
                end
            end
        end
    end

    // the reply prepared by the previous frame leaves msb first, changing on falling sclk
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            tx_shift_r <= 32'h00000000;
            sdo        <= 1'b0;
            sdo_en     <= 1'b0;
        end else if (ce) begin
            if (state_r == cfg_pkg::LINK_IDLE && !cs_s_r) begin
                tx_shift_r <= reply_r;
                sdo        <= reply_r[31];
                sdo_en     <= 1'b1;
            end else if (state_r == cfg_pkg::LINK_SHIFT && !cs_s_r && sclk_fall) begin
                tx_shift_r <= {tx_shift_r[30:0], 1'b0};
                sdo        <= tx_shift_r[30];
            end else if (cs_s_r) begin
                sdo_en     <= 1'b0;
                sdo        <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration storage and reply

    // a write frame stores bits 26:1; bad parity or a read frame leaves them alone
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            cfg_r[0] <= cfg_pkg::CFG_RESET;
            cfg_r[1] <= cfg_pkg::CFG_RESET;
        end else if (ce) begin
            if (state_r == cfg_pkg::LINK_EVAL && frame_ok && frm.is_write) begin
                if (frm.sel_ch4) begin
                    cfg_r[0] <= rx_shift_r[cfg_pkg::STORE_MSB:cfg_pkg::STORE_LSB];
                end else begin
                    cfg_r[1] <= rx_shift_r[cfg_pkg::STORE_MSB:cfg_pkg::STORE_LSB];
                end
            end
        end
    end

    // reply carries the contents as they stand once the frame has been applied
    always_comb begin
        if (frm.is_write) begin
            reply_body = rx_shift_r[cfg_pkg::STORE_MSB:cfg_pkg::STORE_LSB];
        end else if (frm.sel_ch4) begin
            reply_body = cfg_r[0];
        end else begin
            reply_body = cfg_r[1];
        end
    end

    // reply and frame status, both refreshed once per completed frame
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            reply_r      <= cfg_pkg::ERR_REPLY;
            frame_done   <= 1'b0;
            parity_error <= 1'b0;
            frame_error  <= 1'b0;
        end else if (ce) begin
            frame_done <= (state_r == cfg_pkg::LINK_EVAL);
            if (state_r == cfg_pkg::LINK_EVAL) begin
                parity_error <= !frm.parity_ok;
                frame_error  <= (bit_cnt_r != cfg_pkg::FRAME_LEN)
                                || !(frm.sel_ch4 || frm.sel_ch5);
                if (frame_ok) begin
                    reply_r <= {rx_shift_r[31:27], reply_body,
                                ~^{rx_shift_r[31:27], reply_body}};
                end else begin
                    reply_r <= cfg_pkg::ERR_REPLY;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // group settings held in the two frames

    assign bridge_one_group_enable      = cfg_r[0][cfg_pkg::BRIDGE1_BIT];
    assign peak_hold_one_group_enable   = cfg_r[0][cfg_pkg::PH1_BIT];
    assign peak_hold_one_open_load_mask = cfg_r[0][cfg_pkg::PH1_MASK_BIT];
    assign bridge_two_crossover_delay   = cfg_r[1][cfg_pkg::DEAD_MSB:cfg_pkg::DEAD_LSB];
    assign bridge_two_timer_extension   = cfg_r[1][cfg_pkg::EXT2_BIT];

    // derived group behaviour, registered so every output leaves a flip-flop
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ph1_no_fault_report    <= 1'b0;
            ph1_no_diag_report     <= 1'b0;
            crossover_delay_cycles <= cfg_pkg::DEAD_BASE_CYC;
            shared_diag_timer      <= 1'b0;
            ch4_diag_timer_active  <= 1'b1;
        end else if (ce) begin
            // masking strategy only matters while peak-and-hold one is set up
            ph1_no_fault_report <= cfg_r[0][cfg_pkg::PH1_BIT]
                                   & ~cfg_r[0][cfg_pkg::PH1_MASK_BIT];
            ph1_no_diag_report  <= cfg_r[0][cfg_pkg::PH1_BIT]
                                   & cfg_r[0][cfg_pkg::PH1_MASK_BIT];
            // 1 us doubled per code step
            crossover_delay_cycles <= cfg_pkg::DEAD_BASE_CYC
                                      << cfg_r[1][cfg_pkg::DEAD_MSB:cfg_pkg::DEAD_LSB];
            // channel-5 timer governs 6-8 only with bridge two up and no extension
            shared_diag_timer <= bridge_two_group_enable
                                 & ~cfg_r[1][cfg_pkg::EXT2_BIT];
            // channel-4 timer field has no effect in bridge one without extension
            ch4_diag_timer_active <= ~(cfg_r[0][cfg_pkg::BRIDGE1_BIT]
                                       & ~bridge_one_timer_extension);
        end
    end

    // off-state diagnostic times: channel 4 standard, channel 5 switches table
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            diag_time_t100ns[0] <= cfg_pkg::DIAG_STD_T[0];
            diag_time_t100ns[1] <= cfg_pkg::DIAG_STD_T[0];
        end else if (ce) begin
            diag_time_t100ns[0] <= cfg_pkg::DIAG_STD_T[cfg_r[0][cfg_pkg::DIAG_MSB:cfg_pkg::DIAG_LSB]];
            if (bridge_two_group_enable && !cfg_r[1][cfg_pkg::EXT2_BIT]) begin
                diag_time_t100ns[1] <=
                    cfg_pkg::DIAG_HB_T[cfg_r[1][cfg_pkg::DIAG_MSB:cfg_pkg::DIAG_LSB]];
            end else begin
                diag_time_t100ns[1] <=
                    cfg_pkg::DIAG_STD_T[cfg_r[1][cfg_pkg::DIAG_MSB:cfg_pkg::DIAG_LSB]];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-channel output settings; index 0 is channel 4, index 1 is channel 5

    logic [1:0]                    in_bridge;

    // channel 4 belongs to bridge one, channel 5 to bridge two
    assign in_bridge = {bridge_two_group_enable, cfg_r[0][cfg_pkg::BRIDGE1_BIT]};

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        assign overcurrent_readback_select[ch] = cfg_r[ch][cfg_pkg::OC_READ_BIT];
        assign overcurrent_threshold_code[ch]  =
            cfg_r[ch][cfg_pkg::OC_THR_MSB:cfg_pkg::OC_THR_LSB];
        assign overcurrent_thermal_comp[ch]    =
            cfg_r[ch][cfg_pkg::THERM_MSB:cfg_pkg::THERM_LSB];
        assign overcurrent_supply_comp[ch]     = cfg_r[ch][cfg_pkg::SUPPLY_BIT];
        assign overcurrent_blank_time[ch]      =
            cfg_r[ch][cfg_pkg::BLANK_MSB:cfg_pkg::BLANK_LSB];
        assign restart_policy[ch]              = cfg_r[ch][cfg_pkg::RESTART_BIT];
        assign current_sense_method[ch]        = cfg_r[ch][cfg_pkg::SENSE_BIT];
        assign open_load_current_high[ch]      = cfg_r[ch][cfg_pkg::OL_CUR_BIT];
        assign gate_current_select[ch]         =
            cfg_r[ch][cfg_pkg::GATE_MSB:cfg_pkg::GATE_LSB];
        assign pmos_select[ch]                 = cfg_r[ch][cfg_pkg::PMOS_BIT];
        assign side_select[ch]                 = cfg_r[ch][cfg_pkg::SIDE_BIT];
        assign output_enable[ch]               = cfg_r[ch][cfg_pkg::ENABLE_BIT];

        // blank time, its meaning, and the effective restart behaviour
        always_ff @(posedge ref_clk or negedge rst_sync_r) begin
            if (!rst_sync_r) begin
                blank_time_t100ns[ch]     <= cfg_pkg::BLANK_T[0];
                blank_delays_eval[ch]     <= 1'b1;
                restart_after_readout[ch] <= 1'b0;
            end else if (ce) begin
                blank_time_t100ns[ch] <=
                    cfg_pkg::BLANK_T[cfg_r[ch][cfg_pkg::BLANK_MSB:cfg_pkg::BLANK_LSB]];
                // in shunt mode the time only gates the no-overcurrent code
                blank_delays_eval[ch] <= ~cfg_r[ch][cfg_pkg::SENSE_BIT];
                // a bridge can only come back after its latches are read out
                restart_after_readout[ch] <= cfg_r[ch][cfg_pkg::RESTART_BIT]
                                             | in_bridge[ch];
            end
        end
    end

endmodule

/* core/cfg_pkg.sv */
// shared constants for the channel-4 / channel-5 serial configuration frames
package cfg_pkg;

    // frame layout
    localparam int          FRAME_BITS   = 32;
    localparam int          CNT_BITS     = 6;
    localparam int          CMD_MSB      = 31;
    localparam int          CMD_LSB      = 28;
    localparam int          RW_BIT       = 27;
    localparam int          PARITY_BIT   = 0;
    localparam int          STORE_MSB    = 26;
    localparam int          STORE_LSB    = 1;
    localparam logic [3:0]  CMD_CH4      = 4'h4;
    localparam logic [3:0]  CMD_CH5      = 4'h5;
    localparam logic        RW_WRITE     = 1'b0;
    localparam logic [5:0]  FRAME_LEN    = 6'h20;
    localparam logic [5:0]  CNT_MAX      = 6'h3F;

    // channel-4 frame group bits
    localparam int          BRIDGE1_BIT  = 26;
    localparam int          PH1_MASK_BIT = 25;
    localparam int          PH1_BIT      = 24;
    // channel-5 frame group bits
    localparam int          DEAD_MSB     = 26;
    localparam int          DEAD_LSB     = 25;
    localparam int          EXT2_BIT     = 24;

    // per-channel fields, same place in both frames
    localparam int          DIAG_MSB     = 23;
    localparam int          DIAG_LSB     = 22;
    localparam int          OC_READ_BIT  = 21;
    localparam int          OC_THR_MSB   = 20;
    localparam int          OC_THR_LSB   = 15;
    localparam int          THERM_MSB    = 14;
    localparam int          THERM_LSB    = 13;
    localparam int          SUPPLY_BIT   = 12;
    localparam int          BLANK_MSB    = 11;
    localparam int          BLANK_LSB    = 9;
    localparam int          RESTART_BIT  = 8;
    localparam int          SENSE_BIT    = 7;
    localparam int          OL_CUR_BIT   = 6;
    localparam int          GATE_MSB     = 5;
    localparam int          GATE_LSB     = 4;
    localparam int          PMOS_BIT     = 3;
    localparam int          SIDE_BIT     = 2;
    localparam int          ENABLE_BIT   = 1;

    // values after reset
    localparam logic [26:1] CFG_RESET    = 26'h0000000;
    localparam logic [31:0] ERR_REPLY    = 32'h00000001;

    // times in units of 100 ns
    localparam logic [15:0] DIAG_STD_T [0:3] = '{16'h0100, 16'h0264, 16'h0420, 16'h05DC};
    localparam logic [15:0] DIAG_HB_T  [0:3] = '{16'h0070, 16'h0121, 16'h0190, 16'h0200};
    localparam logic [15:0] BLANK_T    [0:7] = '{16'h006F, 16'h009C, 16'h00C8, 16'h0137,
                                                 16'h01A6, 16'h0215, 16'h03D2, 16'h058E};

    // crossover delay: base step in ns, converted to clock cycles (rounded up)
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          DEAD_BASE_NS    = 1000;
    localparam logic [9:0]  DEAD_BASE_CYC   =
        10'((DEAD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // serial receiver states
    typedef enum logic [2:0] {
        LINK_IDLE  = 3'b001,
        LINK_SHIFT = 3'b010,
        LINK_EVAL  = 3'b100
    } link_state_type;

endpackage

/* core/frame_decoder.sv */
// combinational decode of a received 32-bit configuration frame
`timescale 1ns/100ps
module frame_decoder (
    frame_if.decode f
);

    // parity bit is 1 when the other 31 bits hold an even count of ones
    assign f.parity_ok = (f.word[cfg_pkg::PARITY_BIT] == ~^f.word[31:1]);

    // command code selects the frame; channel-5 code taken as the next in sequence
    assign f.sel_ch4 = (f.word[cfg_pkg::CMD_MSB:cfg_pkg::CMD_LSB] == cfg_pkg::CMD_CH4);
    assign f.sel_ch5 = (f.word[cfg_pkg::CMD_MSB:cfg_pkg::CMD_LSB] == cfg_pkg::CMD_CH5);

    // access type: write-and-read or read only
    assign f.is_write = (f.word[cfg_pkg::RW_BIT] == cfg_pkg::RW_WRITE);

endmodule

/* core/frame_if.sv */
// carrier between the frame shifter and the frame decoder
`timescale 1ns/100ps
interface frame_if;
    logic [31:0] word;
    logic        parity_ok;
    logic        sel_ch4;
    logic        sel_ch5;
    logic        is_write;

    modport source (output word, input parity_ok, sel_ch4, sel_ch5, is_write);
    modport decode (input word, output parity_ok, sel_ch4, sel_ch5, is_write);
endinterface

/* tb/bridge_cfg_props.sv */
// port-level checks of the channel-4/5 configuration block
`timescale 1ns/100ps
module bridge_cfg_props (
    input wire logic            ref_clk,
    input wire logic            reset_n,
    input wire logic            cs_n,
    input wire logic            sdo_en,
    input wire logic            frame_done,
    input wire logic            parity_error,
    input wire logic            bridge_one_group_enable,
    input wire logic            bridge_one_timer_extension,
    input wire logic            ch4_diag_timer_active,
    input wire logic [1:0]      bridge_two_crossover_delay,
    input wire logic [9:0]      crossover_delay_cycles,
    input wire logic [1:0][5:0] overcurrent_threshold_code
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    done_pulse_a: assert property (frame_done |=> !frame_done)
        else $error("frame done held longer than one cycle");
    desel_done_a: assert property ($rose(cs_n) |-> ##[3:6] frame_done)
        else $error("no frame done after deselect");
    select_drive_a: assert property ($fell(cs_n) |-> ##[2:6] sdo_en)
        else $error("reply driver not enabled after select");
    release_drive_a: assert property ($rose(cs_n) |-> ##[2:6] !sdo_en)
        else $error("reply driver still enabled after deselect");
    delay_cycles_a: assert property (crossover_delay_cycles ==
        10'(10'h064 << $past(bridge_two_crossover_delay))) else $error("bad crossover delay");
    delay_update_a: assert property ($changed(bridge_two_crossover_delay) |-> frame_done)
        else $error("crossover code changed outside a frame end");
    thr_keep_a: assert property ($changed(overcurrent_threshold_code) |-> !parity_error)
        else $error("threshold changed by a bad-parity frame");
    ch4_timer_a: assert property (ch4_diag_timer_active ==
        !$past(bridge_one_group_enable && !bridge_one_timer_extension)) else $error("bad ch4 timer");
endmodule
bind bridge_peak_hold_channel_config bridge_cfg_props chk (.ref_clk(ref_clk),
    .reset_n(reset_n), .cs_n(cs_n), .sdo_en(sdo_en), .frame_done(frame_done),
    .parity_error(parity_error), .bridge_one_group_enable(bridge_one_group_enable),
    .bridge_one_timer_extension(bridge_one_timer_extension),
    .ch4_diag_timer_active(ch4_diag_timer_active),
    .bridge_two_crossover_delay(bridge_two_crossover_delay),
    .crossover_delay_cycles(crossover_delay_cycles),
    .overcurrent_threshold_code(overcurrent_threshold_code));

/* tb/bridge_peak_hold_channel_config_tb_top.sv */
// self-checking bench for the channel-4/5 configuration frames
`timescale 1ns/100ps
module bridge_peak_hold_channel_config_tb_top;
    localparam logic [31:0] W4 = 32'h45A5C3F2, W5 = 32'h56C24A7E, R4 = 32'h48000000;
    logic ref_clk, reset_n, ce, sclk, cs_n, mosi, sdo, sdo_en, b2_en, b1_ext, parity_error;
    logic frame_error, bridge_one_group_enable, peak_hold_one_group_enable, ph1_no_fault_report;
    logic [9:0]       crossover_delay_cycles;
    logic [1:0][15:0] diag_time_t100ns;
    logic [1:0][5:0]  overcurrent_threshold_code;
    logic [1:0]       restart_after_readout, output_enable;
    logic [31:0]      rx;
    logic             shared_diag_timer;
    int               bad_count, tests_run;
    bridge_peak_hold_channel_config uut (
        .ref_clk, .reset_n, .ce, .sclk, .cs_n, .mosi, .bridge_two_group_enable(b2_en),
        .bridge_one_timer_extension(b1_ext), .sdo, .sdo_en, .frame_done(), .parity_error,
        .frame_error, .bridge_one_group_enable, .peak_hold_one_group_enable,
        .peak_hold_one_open_load_mask(), .ph1_no_fault_report, .ph1_no_diag_report(),
        .bridge_two_crossover_delay(), .crossover_delay_cycles, .bridge_two_timer_extension(),
        .shared_diag_timer, .ch4_diag_timer_active(), .diag_time_t100ns,
        .overcurrent_readback_select(), .overcurrent_threshold_code, .overcurrent_thermal_comp(),
        .overcurrent_supply_comp(), .overcurrent_blank_time(), .blank_time_t100ns(),
        .blank_delays_eval(), .restart_policy(), .restart_after_readout,
        .current_sense_method(), .open_load_current_high(), .gate_current_select(),
        .pmos_select(), .side_select(), .output_enable);
    host_spi_model host (.ref_clk, .sdo, .sdo_en, .sclk, .cs_n, .mosi);
    ////////////////////////////////////////////////////////////////////////////////
    // expected reply: header of the answered frame, stored bits, odd parity
    function automatic logic [31:0] rep(logic [4:0] h, logic [25:0] s);
        return {h, s, ~^{h, s}};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // hang guard well beyond the seven frames of the run
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        final_report();
    end
    initial begin
        {reset_n, b2_en, b1_ext} = 3'h0;
        ce = 1'b1;
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        host.xfer(W4, 32, 1'b0, rx);
        chk(bridge_one_group_enable, W4[26]);
        chk(peak_hold_one_group_enable, W4[24]);
        chk(ph1_no_fault_report, 32'h1);
        chk(diag_time_t100ns[0], 16'h0420);
        chk(overcurrent_threshold_code[0], W4[20:15]);
        chk(restart_after_readout[0], 32'h1);
        chk(output_enable[0], W4[1]);
        b2_en = 1'b1;
        host.xfer(W5, 32, 1'b0, rx);
        chk(rx, rep(W4[31:27], W4[26:1]));
        chk(overcurrent_threshold_code[1], W5[20:15]);
        chk(crossover_delay_cycles, 10'h320);
        chk(diag_time_t100ns[1], 16'h0200);
        chk(shared_diag_timer, 32'h1);
        b1_ext = 1'b1;
        host.xfer(R4, 32, 1'b0, rx);
        chk(rx, rep(W5[31:27], W5[26:1]));
        chk(overcurrent_threshold_code[0], W4[20:15]);
        chk({parity_error, frame_error}, 32'h0);
        host.xfer(32'h40000000, 32, 1'b1, rx);
        chk(rx, rep(R4[31:27], W4[26:1]));
        chk(parity_error, 32'h1);
        chk(output_enable[0], W4[1]);
        host.xfer(32'hB0000000, 32, 1'b0, rx);
        chk(rx, 32'h00000001);
        chk(frame_error, 32'h1);
        host.xfer(32'h80000000, 31, 1'b0, rx);
        chk(frame_error, 32'h1);
        host.xfer(R4, 32, 1'b0, rx);
        chk(rx, 32'h00000001);
        b2_en = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(diag_time_t100ns[1], 16'h05DC);
        final_report();
    end
endmodule

/* tb/host_spi_model.sv */
// host serial master sending configuration frames and collecting replies
`timescale 1ns/100ps
module host_spi_model (
    input  wire logic ref_clk,
    input  wire logic sdo,
    input  wire logic sdo_en,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi
);
    logic [31:0] word;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // mode 0, msb first; 4-cycle half periods stay clear of the 3-cycle minimum
    task automatic xfer(input logic [31:0] tx, input int n, input logic flip,
                        output logic [31:0] rx);
        rx = '0;
        word = {tx[31:1], (~^tx[31:1]) ^ flip};
        @(negedge ref_clk) cs_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        for (int i = 31; i > 31 - n; i--) begin
            mosi = word[i];
            repeat (4) @(negedge ref_clk);
            sclk = 1'b1;
            rx = {rx[30:0], sdo_en ? sdo : 1'bx};
            repeat (4) @(negedge ref_clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        cs_n = 1'b1;
        mosi = ~mosi; // released line must not show the last bit
        repeat (10) @(negedge ref_clk);
    endtask
endmodule
